// File: core/goc_ctrl.sv
// Gate operator controller: sequences gate motion from stations, limits and sensors.
// Assumes pin inputs are clean contacts, active high, asynchronous to the clock.
//
// Behaviour
// - Auto-close after 0..124 s preset when open.
// - Auto-close only with switch one on.
// - Max-run countdown restarts on every start.
// - Max-run expiry (15..100 s) stops motor.
// - Max-run expiry locks out, sounds alarm.
// - Open sense trip acts only while opening.
// - Close sense trip acts only while closing.
// - Switch two: warning two seconds early.
// - Switch two off: warning only while running.
// - Switch three: open-stop-close-stop cycle.
// - Switch three off: open, or close when open.
// - Switch four swaps motor rotation for hand.
// - Switch five: unlock, wait one second.
// - Reversal pause three or 1.5 seconds.
// - Switch six disables DC brake.
// - Switch eight selects slave role.
// - Slave follows master motion commands.
// - Limit of travel direction removes drive.
// - Switch seven has no effect.
// - Reverse while closing travels fully open.
// - Obstruction stops, backs off, needs command.
// - Second obstruction before a limit locks out.
// - Hold-open keeps gate open, no closing.
`timescale 1ns/10ps
module goc_ctrl
   import goc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire goc_cmd_s i_cmd,
   input wire goc_sense_s i_sense,
   input wire logic [7:0] i_dip,
   input wire logic [6:0] i_auto_close_s,
   input wire logic [6:0] i_max_run_s,
   input wire logic i_master_open,
   input wire logic i_master_close,
   output logic o_motor_fwd,
   output logic o_motor_rev,
   output logic o_warn,
   output logic o_lock_release,
   output logic o_brake_en,
   output logic o_alarm,
   output logic o_lockout,
   output logic o_slave_open,
   output logic o_slave_close,
   output logic o_at_open,
   output logic o_at_close
);

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   localparam int unsigned IN_W = CMD_W + SENSE_W + 10;
   logic [IN_W-1:0] meta_r;
   logic [IN_W-1:0] sync_r;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {i_cmd, i_sense, i_dip, i_master_open, i_master_close};
         sync_r <= meta_r;
      end
   end
   goc_cmd_s cmd;
   goc_sense_s sense;
   logic [7:0] dip;
   logic m_open;
   logic m_close;
   assign {cmd, sense, dip, m_open, m_close} = sync_r;

   // Momentary commands act on their rising edge; levels act directly.
   goc_cmd_s cmd_d_r;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         cmd_d_r <= '0;
      end else begin
         cmd_d_r <= cmd;
      end
   end
   logic open_ev;
   logic close_ev;
   logic btn_ev;
   logic stop_lvl;
   assign open_ev = cmd.open_cmd & ~cmd_d_r.open_cmd;
   assign close_ev = cmd.close_cmd & ~cmd_d_r.close_cmd;
   assign btn_ev = cmd.single_btn & ~cmd_d_r.single_btn;
   assign stop_lvl = cmd.stop_cmd;

   // ************************************************************
   // Timebase
   // ************************************************************
   logic [TICK_W-1:0] div_r;
   logic tick;
   assign tick = (div_r == TICK_W'(TICK_CYCLES - 1));
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         div_r <= '0;
      end else begin
         div_r <= tick ? '0 : div_r + 1'b1;
      end
   end

   // ************************************************************
   // Position, direction and state
   // ************************************************************
   goc_state_e state_r;
   logic dir_open_r;        // Direction of the pending or current run.
   logic last_open_r;       // Direction of the last motor run, for reversal pause.
   logic ran_r;
   logic at_open_r;
   logic at_close_r;
   logic obstr_once_r;
   logic ac_block_r;
   logic [1:0] step_r;
   logic [10:0] dly_r;
   logic [9:0] run_r;
   logic [10:0] ac_r;
   logic running;
   logic slave;
   logic open_lim;
   logic close_lim;
   logic obstr_hit;
   logic max_exp;

   assign running = (state_r == GOC_RUN) || (state_r == GOC_BACKOFF);
   assign slave = dip[SW_SLAVE];
   assign open_lim = sense.open_limit_switch;
   assign close_lim = sense.close_limit_switch;
   // Sense trips share the obstruction path and count only in their own direction.
   assign obstr_hit = (state_r == GOC_RUN) &&
      (dir_open_r ? (cmd.open_obstr | sense.open_sense_trip)
                  : (cmd.close_obstr | sense.close_sense_trip));
   assign max_exp = (state_r == GOC_RUN) && (run_r == '0);

   // Requested new motion, resolved from every command source.
   logic want_open;
   logic want_close;
   logic want_stop;
   always_comb begin
      want_open = 1'b0;
      want_close = 1'b0;
      want_stop = 1'b0;
      if (slave) begin
         want_open = m_open & ~running;
         want_close = m_close & ~running & ~m_open;
      end else begin
         want_open = open_ev | (cmd.hold_open & ~at_open_r);
         want_close = close_ev;
         if (btn_ev) begin
            if (dip[SW_FOUR_STEP]) begin
               case (step_r)
                  2'd0: want_open = 1'b1;
                  2'd2: want_close = 1'b1;
                  default: want_stop = 1'b1;
               endcase
            end else if (at_open_r) begin
               want_close = 1'b1;
            end else begin
               want_open = 1'b1;
            end
         end
         if (cmd.reverse && running && !dir_open_r) begin
            want_open = 1'b1;
         end
         if (cmd.hold_open) begin
            want_close = 1'b0;
         end
      end
      if (want_open) begin
         want_close = 1'b0;
      end
   end

   logic go_req;
   logic go_open;
   assign go_req = (want_open && !(dir_open_r && running) && !at_open_r) ||
                   (want_close && !(!dir_open_r && running) && !at_close_r);
   assign go_open = want_open;

   // Delay before motor drive: reversal pause, then prewarn, then unlock.
   logic [10:0] rev_ticks;
   assign rev_ticks = dip[SW_LONG_REV] ? REV_LONG_TICKS : REV_SHORT_TICKS;

   // Auto-close expiry: preset in seconds scaled to ticks.
   logic ac_exp;
   assign ac_exp = dip[SW_AUTO_CLOSE] && at_open_r && !ac_block_r && (state_r == GOC_IDLE) &&
      !cmd.open_cmd && !cmd.reverse && !cmd.open_obstr && !cmd.close_obstr &&
      !cmd.hold_open && !slave && (ac_r == '0);

   // ************************************************************
   // Main sequencer
   // ************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_r <= GOC_IDLE;
         dir_open_r <= 1'b1;
         last_open_r <= 1'b1;
         ran_r <= 1'b0;
         dly_r <= '0;
         obstr_once_r <= 1'b0;
      end else begin
         case (state_r)
            GOC_IDLE, GOC_HALT: begin
               if (!stop_lvl && (go_req || ac_exp)) begin
                  dir_open_r <= go_open;
                  if (ran_r && (go_open != last_open_r)) begin
                     dly_r <= rev_ticks;
                     state_r <= GOC_REVWAIT;
                  end else begin
                     dly_r <= PREWARN_TICKS;
                     state_r <= dip[SW_PREWARN] ? GOC_WARN : GOC_UNLOCK;
                     if (!dip[SW_PREWARN]) dly_r <= UNLOCK_TICKS;
                  end
               end
            end
            GOC_REVWAIT: begin
               if (stop_lvl) begin
                  state_r <= GOC_IDLE;
               end else if (tick) begin
                  if (dly_r <= 11'd1) begin
                     dly_r <= dip[SW_PREWARN] ? PREWARN_TICKS : UNLOCK_TICKS;
                     state_r <= dip[SW_PREWARN] ? GOC_WARN : GOC_UNLOCK;
                  end else begin
                     dly_r <= dly_r - 1'b1;
                  end
               end
            end
            GOC_WARN: begin
               if (stop_lvl) begin
                  state_r <= GOC_IDLE;
               end else if (tick) begin
                  if (dly_r <= 11'd1) begin
                     dly_r <= UNLOCK_TICKS;
                     state_r <= GOC_UNLOCK;
                  end else begin
                     dly_r <= dly_r - 1'b1;
                  end
               end
            end
            GOC_UNLOCK: begin
               if (stop_lvl) begin
                  state_r <= GOC_IDLE;
               end else if (!dip[SW_SOL_LOCK]) begin
                  state_r <= GOC_RUN;
               end else if (tick) begin
                  if (dly_r <= 11'd1) state_r <= GOC_RUN;
                  else dly_r <= dly_r - 1'b1;
               end
               last_open_r <= dir_open_r;
               ran_r <= 1'b1;
            end
            GOC_RUN: begin
               if ((dir_open_r && open_lim) || (!dir_open_r && close_lim)) begin
                  state_r <= GOC_IDLE;
                  obstr_once_r <= 1'b0;
               end else if (max_exp) begin
                  state_r <= GOC_LOCKOUT;
               end else if (obstr_hit) begin
                  if (obstr_once_r) begin
                     state_r <= GOC_LOCKOUT;
                  end else begin
                     obstr_once_r <= 1'b1;
                     dir_open_r <= ~dir_open_r;
                     last_open_r <= ~dir_open_r;
                     dly_r <= BACKOFF_TICKS;
                     state_r <= GOC_BACKOFF;
                  end
               end else if (stop_lvl || want_stop) begin
                  state_r <= GOC_IDLE;
               end else if (go_req) begin
                  dir_open_r <= go_open;
                  dly_r <= rev_ticks;
                  state_r <= GOC_REVWAIT;
               end
            end
            GOC_BACKOFF: begin
               if ((dir_open_r && open_lim) || (!dir_open_r && close_lim)) begin
                  state_r <= GOC_HALT;
               end else if (tick) begin
                  if (dly_r <= 11'd1) state_r <= GOC_HALT;
                  else dly_r <= dly_r - 1'b1;
               end
            end
            GOC_LOCKOUT: begin
               state_r <= GOC_LOCKOUT;
            end
            default: state_r <= GOC_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Position, four-step cycle and auto-close disable
   // ************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         at_open_r <= 1'b0;
         at_close_r <= 1'b0;
         step_r <= 2'd0;
         ac_block_r <= 1'b0;
      end else begin
         if (open_lim) at_open_r <= 1'b1;
         else if (running) at_open_r <= 1'b0;
         if (close_lim) at_close_r <= 1'b1;
         else if (running) at_close_r <= 1'b0;
         if (btn_ev && dip[SW_FOUR_STEP] && !slave) step_r <= step_r + 2'd1;
         if (obstr_hit) ac_block_r <= 1'b1;
         else if (go_req && state_r == GOC_HALT) ac_block_r <= 1'b0;
      end
   end

   // ************************************************************
   // Max-run and auto-close counters, in ticks
   // ************************************************************
   logic [6:0] max_s;
   assign max_s = (i_max_run_s < MAX_RUN_MIN_S) ? MAX_RUN_MIN_S :
                  (i_max_run_s > MAX_RUN_MAX_S) ? MAX_RUN_MAX_S : i_max_run_s;
   logic [6:0] ac_s;
   assign ac_s = (i_auto_close_s > AUTO_CLOSE_MAX_S) ? AUTO_CLOSE_MAX_S : i_auto_close_s;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         run_r <= '0;
         ac_r <= '0;
      end else begin
         if (state_r == GOC_UNLOCK) run_r <= 10'(max_s * TICKS_PER_S);
         else if (state_r == GOC_RUN && tick && run_r != '0) run_r <= run_r - 1'b1;
         if (!at_open_r || state_r != GOC_IDLE || cmd.open_cmd || cmd.reverse ||
             cmd.hold_open || cmd.open_obstr || cmd.close_obstr) begin
            ac_r <= 11'(ac_s * TICKS_PER_S);
         end else if (tick && ac_r != '0) begin
            ac_r <= ac_r - 1'b1;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   logic motor_on;
   assign motor_on = running;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_motor_fwd <= 1'b0;
         o_motor_rev <= 1'b0;
         o_warn <= 1'b0;
         o_lock_release <= 1'b0;
         o_brake_en <= 1'b0;
         o_alarm <= 1'b0;
         o_lockout <= 1'b0;
         o_slave_open <= 1'b0;
         o_slave_close <= 1'b0;
         o_at_open <= 1'b0;
         o_at_close <= 1'b0;
      end else begin
         // Hand swaps rotation, never the sense of open and close.
         o_motor_fwd <= motor_on && (dir_open_r ^ dip[SW_LEFT_HAND]);
         o_motor_rev <= motor_on && !(dir_open_r ^ dip[SW_LEFT_HAND]);
         o_warn <= motor_on || (state_r == GOC_WARN) ||
                   (dip[SW_PREWARN] && state_r == GOC_UNLOCK);
         o_lock_release <= dip[SW_SOL_LOCK] && (state_r == GOC_UNLOCK || motor_on);
         o_brake_en <= !dip[SW_LONG_REV] && !motor_on;
         o_alarm <= (state_r == GOC_LOCKOUT);
         o_lockout <= (state_r == GOC_LOCKOUT);
         o_slave_open <= !slave && motor_on && dir_open_r;
         o_slave_close <= !slave && motor_on && !dir_open_r;
         o_at_open <= at_open_r;
         o_at_close <= at_close_r;
      end
   end
   // Switch seven is synchronised with the rest but deliberately read by nothing.

endmodule // goc_ctrl

// File: core/goc_pkg.sv
// Package for the gate operator controller: timing constants, states, carriers.
// Assumes a single 125 MHz clock and presets already digitised to whole seconds.
package goc_pkg;

   // ************************************************************
   // Timebase
   // ************************************************************
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned TICK_MS = 100;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W = 24;
   localparam int unsigned TICKS_PER_S = 1000 / TICK_MS;

   // ************************************************************
   // Delays in timebase ticks
   // ************************************************************
   localparam int unsigned PREWARN_MS = 2000;
   localparam int unsigned UNLOCK_MS = 1000;
   localparam int unsigned REV_LONG_MS = 3000;
   localparam int unsigned REV_SHORT_MS = 1500;
   localparam int unsigned BACKOFF_MS = 500;
   localparam logic [10:0] PREWARN_TICKS = 11'(PREWARN_MS / TICK_MS);
   localparam logic [10:0] UNLOCK_TICKS = 11'(UNLOCK_MS / TICK_MS);
   localparam logic [10:0] REV_LONG_TICKS = 11'(REV_LONG_MS / TICK_MS);
   localparam logic [10:0] REV_SHORT_TICKS = 11'(REV_SHORT_MS / TICK_MS);
   localparam logic [10:0] BACKOFF_TICKS = 11'(BACKOFF_MS / TICK_MS);

   // ************************************************************
   // Preset ranges in seconds
   // ************************************************************
   localparam logic [6:0] AUTO_CLOSE_MIN_S = 7'd0;
   localparam logic [6:0] AUTO_CLOSE_MAX_S = 7'd124;
   localparam logic [6:0] MAX_RUN_MIN_S = 7'd15;
   localparam logic [6:0] MAX_RUN_MAX_S = 7'd100;

   // ************************************************************
   // Configuration switch positions
   // ************************************************************
   localparam int unsigned SW_AUTO_CLOSE = 0;
   localparam int unsigned SW_PREWARN = 1;
   localparam int unsigned SW_FOUR_STEP = 2;
   localparam int unsigned SW_LEFT_HAND = 3;
   localparam int unsigned SW_SOL_LOCK = 4;
   localparam int unsigned SW_LONG_REV = 5;
   localparam int unsigned SW_UNUSED = 6;
   localparam int unsigned SW_SLAVE = 7;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [7:0] {
      GOC_IDLE    = 8'h01,
      GOC_WARN    = 8'h02,
      GOC_UNLOCK  = 8'h04,
      GOC_RUN     = 8'h08,
      GOC_REVWAIT = 8'h10,
      GOC_BACKOFF = 8'h20,
      GOC_HALT    = 8'h40,
      GOC_LOCKOUT = 8'h80
   } goc_state_e;

   typedef struct packed {
      logic open_cmd;
      logic close_cmd;
      logic stop_cmd;
      logic single_btn;
      logic reverse;
      logic open_obstr;
      logic close_obstr;
      logic hold_open;
   } goc_cmd_s;

   typedef struct packed {
      logic open_limit_switch;
      logic close_limit_switch;
      logic open_sense_trip;
      logic close_sense_trip;
   } goc_sense_s;

   localparam int unsigned CMD_W = $bits(goc_cmd_s);
   localparam int unsigned SENSE_W = $bits(goc_sense_s);

endpackage

// File: verification/goc_ctrl_properties.sv
// Concurrent checks on the gate operator controller ports.
// Assumes switches and presets stay steady for several cycles around each check.
`timescale 1ns/10ps
module goc_ctrl_chk
   import goc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire goc_cmd_s i_cmd,
   input wire goc_sense_s i_sense,
   input wire logic [7:0] i_dip,
   input wire logic [6:0] i_auto_close_s,
   input wire logic [6:0] i_max_run_s,
   input wire logic i_master_open,
   input wire logic i_master_close,
   input wire logic o_motor_fwd,
   input wire logic o_motor_rev,
   input wire logic o_warn,
   input wire logic o_lock_release,
   input wire logic o_brake_en,
   input wire logic o_alarm,
   input wire logic o_lockout,
   input wire logic o_slave_open,
   input wire logic o_slave_close,
   input wire logic o_at_open,
   input wire logic o_at_close
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic opening;
   logic running;
   // Switch four swaps the rotation, so opening is judged through it.
   assign opening = i_dip[3] ? o_motor_rev : o_motor_fwd;
   assign running = o_motor_fwd || o_motor_rev;
   sequence s_motor_off;
      !o_motor_fwd && !o_motor_rev;
   endsequence
   sequence s_open_dropped;
      ##[1:6] !opening;
   endsequence
   chk_one_direction: assert property (!(o_motor_fwd && o_motor_rev))
      else $error("motor driven both ways");
   chk_limit_drop: assert property (opening && i_sense.open_limit_switch |-> s_open_dropped)
      else $error("motor kept opening at the limit");
   chk_sense_trip: assert property (opening && i_sense.open_sense_trip |-> s_open_dropped)
      else $error("open sense trip ignored");
   chk_obstr_stop: assert property (opening && i_cmd.open_obstr |-> s_open_dropped)
      else $error("open obstruction ignored");
   chk_run_warn: assert property (running |-> o_warn)
      else $error("warning off while running");
   chk_warn_only_run: assert property ((!i_dip[1])[*4] |-> o_warn == running)
      else $error("warning without motion");
   chk_brake_state: assert property (($stable(i_dip[5]) && !running)[*5] |-> o_brake_en == !i_dip[5])
      else $error("brake level wrong at rest");
   chk_brake_run: assert property (running |-> !o_brake_en)
      else $error("brake applied while running");
   chk_alarm_pair: assert property (o_alarm == o_lockout)
      else $error("alarm and lockout disagree");
   chk_lockout_sticky: assert property (o_lockout |=> o_lockout)
      else $error("lockout released");
   chk_lockout_still: assert property (o_lockout[*2] |-> s_motor_off)
      else $error("motor runs in lockout");
   chk_slave_silent: assert property (i_dip[7][*4] |-> !o_slave_open && !o_slave_close)
      else $error("slave drives pairing outputs");
endmodule // goc_ctrl_chk
bind goc_ctrl goc_ctrl_chk chk_u (.i_ref_clk, .i_rst_n, .i_cmd, .i_sense, .i_dip,
   .i_auto_close_s, .i_max_run_s, .i_master_open, .i_master_close, .o_motor_fwd,
   .o_motor_rev, .o_warn, .o_lock_release, .o_brake_en, .o_alarm, .o_lockout,
   .o_slave_open, .o_slave_close, .o_at_open, .o_at_close);

// File: verification/goc_gate_model.sv
// Behavioural gate: position moves with the motor, limit contacts at both ends.
// Assumes one position step per clock, far quicker than a real gate to keep runs short.
`timescale 1ns/10ps
module goc_gate_model
   import goc_pkg::*;
#(
   parameter int POS_MAX = 60,
   parameter int POS_START = 10
)(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_motor_fwd,
   input wire logic i_motor_rev,
   input wire logic i_left_hand,
   input wire logic [1:0] i_trip,
   output goc_sense_s o_sense
);
   int pos_r;
   logic opening;
   logic closing;
   assign opening = i_left_hand ? i_motor_rev : i_motor_fwd;
   assign closing = i_left_hand ? i_motor_fwd : i_motor_rev;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         pos_r <= POS_START;
      end else if (opening && pos_r < POS_MAX) begin
         pos_r <= pos_r + 1;
      end else if (closing && pos_r > 0) begin
         pos_r <= pos_r - 1;
      end
   end
   // Contacts stay made while the gate rests at an end, as real limit nuts do.
   assign o_sense.open_limit_switch = pos_r >= POS_MAX;
   assign o_sense.close_limit_switch = pos_r <= 0;
   assign o_sense.open_sense_trip = i_trip[1];
   assign o_sense.close_sense_trip = i_trip[0];
endmodule // goc_gate_model

// File: verification/test_gate_operator_controller.sv
// Self-checking bench for the gate operator controller with a behavioural gate.
// Assumes the real tick, so only behaviour within a few thousand cycles is timed.
`timescale 1ns/10ps
module test_gate_operator_controller;
   import goc_pkg::*;
   logic i_ref_clk = 1'h0;
   logic i_rst_n = 1'h0;
   goc_cmd_s cmd = '0;
   goc_sense_s sense;
   logic [7:0] dip = 8'h00;
   logic [6:0] ac_s = 7'h00;
   logic [6:0] mr_s = 7'h0F;
   logic m_open = 1'h0;
   logic m_close = 1'h0;
   logic [1:0] trip = 2'h0;
   logic mf, mr, warn, lrel, brk, alarm, lock, so, sc, at_o, at_c;
   logic [15:0] seed = 16'h8BF6;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   // ************************************************************
   // Clock, design, gate and watchdog
   // ************************************************************
   always #4 i_ref_clk = ~i_ref_clk;
   goc_ctrl dut_u (.i_ref_clk, .i_rst_n, .i_cmd(cmd), .i_sense(sense), .i_dip(dip),
      .i_auto_close_s(ac_s), .i_max_run_s(mr_s), .i_master_open(m_open),
      .i_master_close(m_close), .o_motor_fwd(mf), .o_motor_rev(mr), .o_warn(warn),
      .o_lock_release(lrel), .o_brake_en(brk), .o_alarm(alarm), .o_lockout(lock),
      .o_slave_open(so), .o_slave_close(sc), .o_at_open(at_o), .o_at_close(at_c));
   goc_gate_model gate_u (.i_ref_clk, .i_rst_n, .i_motor_fwd(mf), .i_motor_rev(mr),
      .i_left_hand(dip[3]), .i_trip(trip), .o_sense(sense));
   // The ceiling is nearly four times the expected length of the whole sequence.
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc > 8000) begin
         n_fail++;
         finish_test();
      end
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic restart(input logic [7:0] d);
      @(posedge i_ref_clk);
      i_rst_n <= 1'h0;
      dip <= d;
      cmd <= '0;
      trip <= 2'h0;
      m_open <= 1'h0;
      ac_s <= 7'(seed[15:8] % 8'h7D);
      mr_s <= 7'h0F + 7'(seed[7:4]) * 7'h05;
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'h1;
      cyc_n(6);
      check({mf, mr, warn, lrel, alarm, lock, at_o, at_c}, 8'h00);
      check({7'h00, brk}, {7'h00, ~d[5]});
   endtask
   task automatic press(input logic [7:0] m);
      @(posedge i_ref_clk);
      cmd <= goc_cmd_s'(cmd | m);
      cyc_n(4);
      @(posedge i_ref_clk);
      cmd <= goc_cmd_s'(cmd & ~m);
      #1;
   endtask
   task automatic wait_mot(input logic [1:0] e);
      int k;
      k = 0;
      while ({mf, mr} !== e && k < 200) begin
         cyc_n(1);
         k++;
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      logic [7:0] d;
      logic [1:0] od;
      logic [7:0] sw [2];
      sw = '{8'h02, 8'h10};
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         d = {1'h0, seed[0], seed[1], 1'h0, seed[2], 2'h0, seed[3]};
         od = d[3] ? 2'h1 : 2'h2;
         restart(d);
         press(seed[4] ? 8'h10 : 8'h80);
         wait_mot(od);
         check({6'h00, mf, mr}, {6'h00, od});
         check({5'h00, warn, brk, so}, 8'h05);
         wait_mot(2'h0);
         check({6'h00, mf, at_o}, 8'h01);
      end
      $display("test random open runs done");
      restart(8'h04);
      press(8'h10);
      wait_mot(2'h2);
      check({6'h00, mf, mr}, 8'h02);
      press(8'h10);
      wait_mot(2'h0);
      check({5'h00, mf, mr, at_o}, 8'h00);
      $display("test four step done");
      restart(8'h00);
      press(8'h40);
      wait_mot(2'h1);
      check({6'h00, mf, mr}, 8'h01);
      wait_mot(2'h0);
      check({6'h00, mr, at_c}, 8'h01);
      $display("test close run done");
      for (int i = 0; i < 2; i++) begin
         restart(sw[i]);
         press(8'h80);
         cyc_n(8);
         check({6'h00, warn, lrel}, {6'h00, sw[i][1], sw[i][4]});
         cyc_n(500);
         check({6'h00, mf, mr}, 8'h00);
      end
      $display("test start delays done");
      for (int k = 0; k < 3; k++) begin
         restart(8'h00);
         press(8'h80);
         wait_mot(2'h2);
         @(posedge i_ref_clk);
         if (k == 2) begin
            cmd <= goc_cmd_s'(8'h04);
         end else begin
            trip <= 2'(k + 1);
         end
         cyc_n(10);
         check({7'h00, mf}, {7'h00, k == 0});
      end
      $display("test obstruction done");
      restart(8'h01);
      @(posedge i_ref_clk);
      cmd <= goc_cmd_s'(8'h01);
      wait_mot(2'h2);
      check({6'h00, mf, mr}, 8'h02);
      wait_mot(2'h0);
      cyc_n(300);
      check({5'h00, mf, mr, at_o}, 8'h01);
      $display("test hold open done");
      restart(8'h80);
      press(8'h80);
      cyc_n(40);
      check({6'h00, mf, mr}, 8'h00);
      @(posedge i_ref_clk);
      m_open <= 1'h1;
      wait_mot(2'h2);
      check({5'h00, mf, so, sc}, 8'h04);
      $display("test slave done");
      finish_test();
   end
endmodule // test_gate_operator_controller
